/* pvi_core.sv */
// module: processor-side interrupt, dma and power-fail sequencer
`timescale 1ns/1ps
// Contract
// - every transfer waits for slave response
// - at most one word per 400 ns
// - dma requests win the bus first
// - processor resumes after dma, registers untouched
// - processor allocates bus, samples during transfers
// - four request lines, levels shared
// - grant highest level above running priority
// - push status then program counter
// - load pc and status from vector
// - return pops pc then status
// - request level independent of running priority
// - higher requests nest inside service routines
// - word transfers only, byte_en never set
// - power-fail save then automatic restart
module pvi_core
    import pvi_pkg::*;
#(
    parameter int unsigned LEVELS = pvi_pkg::NUM_LEVELS
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // interrupt and dma requests and power-fail from the bus pins
    input wire logic [LEVELS-1:0] br_pin,
    input wire logic npr_pin,
    input wire logic pwr_fail_pin,
    // device answer to a grant, carrying the vector
    input wire logic vec_valid,
    input wire logic [pvi_pkg::WORD_W-1:0] vec_in,
    // processor side
    input wire logic rti_req,
    input wire logic [pvi_pkg::WORD_W-1:0] pc_in,
    input wire logic [pvi_pkg::WORD_W-1:0] psw_in,
    input wire logic cpu_idle,
    // bus master command and response
    output pvi_pkg::pvi_cmd_t bus_cmd,
    input wire pvi_pkg::pvi_resp_t bus_resp,
    // grants
    output logic [LEVELS-1:0] bg,
    output logic npg,
    output logic cpu_hold,
    // new processor context
    output logic [pvi_pkg::WORD_W-1:0] pc_out,
    output logic [pvi_pkg::WORD_W-1:0] psw_out,
    output logic [pvi_pkg::WORD_W-1:0] sp_out,
    output logic ctx_load,
    output logic halted
);
    import pvi_pkg::*;

    typedef struct packed {
        pvi_state_t st;
        logic [LEVELS-1:0] br_m;
        logic [LEVELS-1:0] br_s;
        logic npr_m;
        logic npr_s;
        logic pf_m;
        logic pf_s;
        logic pf_done;
        logic [LEVELS-1:0] gnt;
        logic [5:0] wcnt;
        logic [WORD_W-1:0] vec;
        logic [WORD_W-1:0] pc;
        logic [WORD_W-1:0] psw;
        logic [WORD_W-1:0] sp;
        logic [WORD_W-1:0] save_pc;
        logic [WORD_W-1:0] save_psw;
        logic load;
        pvi_cmd_t cmd;
    } pvi_core_state_t;

    pvi_core_state_t s_ff;
    pvi_core_state_t nxt_s;
    logic hit;
    logic [LEVELS-1:0] pick;
    logic xfer_done;

    // ----------------------------------------
    // level selection
    // ----------------------------------------
    pvi_level_pick #(.LEVELS(LEVELS)) pvi_level_pick_inst (
        .req(s_ff.br_s),
        .cur_pri(s_ff.psw[PRI_LSB +: PRI_W]),
        .hit(hit),
        .onehot(pick)
    );

    assign xfer_done = s_ff.cmd.cmd && bus_resp.resp;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        nxt_s = s_ff;
        nxt_s.br_m = br_pin;
        nxt_s.br_s = s_ff.br_m;
        nxt_s.npr_m = npr_pin;
        nxt_s.npr_s = s_ff.npr_m;
        nxt_s.pf_m = pwr_fail_pin;
        nxt_s.pf_s = s_ff.pf_m;
        nxt_s.load = 1'b0;
        if (s_ff.wcnt != 6'h00) begin
            nxt_s.wcnt = s_ff.wcnt - 6'h01;
        end
        if (xfer_done) begin
            nxt_s.cmd.cmd = 1'b0;
            nxt_s.wcnt = WCNT_MAX;
        end
        case (s_ff.st)
            ST_IDLE: begin
                if (s_ff.npr_s) begin
                    nxt_s.st = ST_DMA;
                end else if (s_ff.pf_s && !s_ff.pf_done) begin
                    nxt_s.save_pc = pc_in;
                    nxt_s.save_psw = psw_in;
                    nxt_s.st = ST_PF_PS;
                end else if (!s_ff.pf_s && s_ff.pf_done) begin
                    nxt_s.pf_done = 1'b0;
                    nxt_s.vec = PWRFAIL_VEC;
                    nxt_s.st = ST_FETCH_PC;
                end else if (cpu_idle && hit) begin
                    nxt_s.gnt = pick;
                    nxt_s.save_pc = pc_in;
                    nxt_s.save_psw = psw_in;
                    nxt_s.st = ST_GRANT;
                end else if (cpu_idle && rti_req) begin
                    nxt_s.st = ST_POP_PC;
                end
            end
            ST_DMA: begin
                if (!s_ff.npr_s) begin
                    nxt_s.st = ST_IDLE;
                end
            end
            ST_GRANT: begin
                if (vec_valid) begin
                    nxt_s.vec = vec_in & VEC_MASK;
                    nxt_s.gnt = '0;
                    nxt_s.st = ST_PUSH_PS;
                end
            end
            ST_PUSH_PS, ST_PUSH_PC, ST_PF_PS, ST_PF_PC: begin
                if (!s_ff.cmd.cmd && s_ff.wcnt == 6'h00) begin
                    nxt_s.sp = s_ff.sp - ADDR_STEP;
                    nxt_s.cmd = '{cmd: 1'b1, wr: 1'b1, byte_en: 1'b0,
                        addr: s_ff.sp - ADDR_STEP,
                        wdata: (s_ff.st == ST_PUSH_PS || s_ff.st == ST_PF_PS)
                            ? s_ff.save_psw : s_ff.save_pc};
                end
                if (xfer_done) begin
                    case (s_ff.st)
                        ST_PUSH_PS: nxt_s.st = ST_PUSH_PC;
                        ST_PUSH_PC: nxt_s.st = ST_FETCH_PC;
                        ST_PF_PS: nxt_s.st = ST_PF_PC;
                        default: begin
                            nxt_s.pf_done = 1'b1;
                            nxt_s.st = ST_HALTED;
                        end
                    endcase
                end
            end
            ST_FETCH_PC, ST_FETCH_PS, ST_POP_PC, ST_POP_PS: begin
                if (!s_ff.cmd.cmd && s_ff.wcnt == 6'h00) begin
                    nxt_s.cmd = '{cmd: 1'b1, wr: 1'b0, byte_en: 1'b0,
                        addr: (s_ff.st == ST_FETCH_PC) ? s_ff.vec :
                              (s_ff.st == ST_FETCH_PS) ? s_ff.vec + ADDR_STEP : s_ff.sp,
                        wdata: '0};
                end
                if (xfer_done) begin
                    case (s_ff.st)
                        ST_FETCH_PC: begin
                            nxt_s.pc = bus_resp.rdata;
                            nxt_s.st = ST_FETCH_PS;
                        end
                        ST_FETCH_PS: begin
                            nxt_s.psw = bus_resp.rdata;
                            nxt_s.load = 1'b1;
                            nxt_s.st = ST_IDLE;
                        end
                        ST_POP_PC: begin
                            nxt_s.pc = bus_resp.rdata;
                            nxt_s.sp = s_ff.sp + ADDR_STEP;
                            nxt_s.st = ST_POP_PS;
                        end
                        default: begin
                            nxt_s.psw = bus_resp.rdata;
                            nxt_s.sp = s_ff.sp + ADDR_STEP;
                            nxt_s.load = 1'b1;
                            nxt_s.st = ST_IDLE;
                        end
                    endcase
                end
            end
            ST_HALTED: begin
                if (!s_ff.pf_s) begin
                    nxt_s.st = ST_IDLE;
                end
            end
            default: nxt_s.st = ST_IDLE;
        endcase
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_ff <= '{st: ST_IDLE, br_m: '0, br_s: '0, npr_m: 1'b0, npr_s: 1'b0,
                pf_m: 1'b0, pf_s: 1'b0, pf_done: 1'b0, gnt: '0, wcnt: 6'h00,
                vec: 16'h0000, pc: PC_RST, psw: PSW_RST, sp: SP_RST,
                save_pc: 16'h0000, save_psw: 16'h0000, load: 1'b0, cmd: '0};
        end else begin
            s_ff <= nxt_s;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign bus_cmd = s_ff.cmd;
    assign bg = s_ff.gnt;
    assign npg = (s_ff.st == ST_DMA);
    assign cpu_hold = (s_ff.st != ST_IDLE);
    assign pc_out = s_ff.pc;
    assign psw_out = s_ff.psw;
    assign sp_out = s_ff.sp;
    assign ctx_load = s_ff.load;
    assign halted = (s_ff.st == ST_HALTED);
endmodule // pvi_core

/* pvi_pkg.sv */
// package: constants and carrier types for the priority vectored interrupt block
package pvi_pkg;
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned WORD_PERIOD_NS = 400;
    localparam int unsigned WORD_CYCLES = (WORD_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned WORD_W = 16;
    localparam int unsigned BYTE_W = 8;
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned NUM_LEVELS = 4;
    localparam int unsigned LVL_BASE = 4;
    localparam int unsigned PRI_LSB = 5;
    localparam int unsigned PRI_W = 3;
    localparam logic [15:0] PSW_RST = 16'h00E0;
    localparam logic [15:0] PC_RST = 16'h0000;
    localparam logic [15:0] SP_RST = 16'h0200;
    localparam logic [15:0] PWRFAIL_VEC = 16'h0018;
    localparam logic [15:0] ADDR_STEP = 16'h0002;
    localparam logic [15:0] VEC_MASK = 16'h01FC;
    localparam logic [5:0] WCNT_MAX = 6'(WORD_CYCLES - 1);

    typedef enum logic [11:0] {
        ST_IDLE = 12'h001, ST_GRANT = 12'h002, ST_PUSH_PS = 12'h004, ST_PUSH_PC = 12'h008,
        ST_FETCH_PC = 12'h010, ST_FETCH_PS = 12'h020, ST_POP_PC = 12'h040,
        ST_POP_PS = 12'h080, ST_DMA = 12'h100, ST_PF_PS = 12'h200, ST_PF_PC = 12'h400,
        ST_HALTED = 12'h800
    } pvi_state_t;

    typedef struct packed {
        logic cmd;
        logic wr;
        logic byte_en;
        logic [ADDR_W-1:0] addr;
        logic [WORD_W-1:0] wdata;
    } pvi_cmd_t;

    typedef struct packed {
        logic resp;
        logic [WORD_W-1:0] rdata;
    } pvi_resp_t;
endpackage

/* pvi_level_pick.sv */
// module: highest pending request level above the running priority
`timescale 1ns/1ps
module pvi_level_pick #(
    parameter int unsigned LEVELS = 4
) (
    // requests and priority
    input wire logic [LEVELS-1:0] req,
    input wire logic [2:0] cur_pri,
    // selection
    output logic hit,
    output logic [LEVELS-1:0] onehot
);
    import pvi_pkg::*;
    logic [LEVELS-1:0] above;
    genvar g;
    generate
        for (g = 0; g < LEVELS; g++) begin : g_lvl
            assign above[g] = req[g] && (3'(LVL_BASE + g) > cur_pri);
        end
    endgenerate
    always_comb begin
        onehot = '0;
        for (int i = 0; i < LEVELS; i++) begin
            if (above[i]) begin
                onehot = '0;
                onehot[i] = 1'b1;
            end
        end
    end
    assign hit = |above;
endmodule // pvi_level_pick

/* pvi_core_asserts.sv */
// checker: timing relations at the sequencer ports
`timescale 1ns/1ps
module pvi_core_asserts
    import pvi_pkg::*;
#(
    parameter int unsigned LEVELS = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // watched ports
    input wire logic npr_pin,
    input wire logic vec_valid,
    input wire pvi_pkg::pvi_cmd_t bus_cmd,
    input wire pvi_pkg::pvi_resp_t bus_resp,
    input wire logic [LEVELS-1:0] bg,
    input wire logic npg,
    input wire logic cpu_hold,
    input wire logic ctx_load
);
    // ----------------------------------------
    // cycles since last response
    // ----------------------------------------
    logic [5:0] gap_ff;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) gap_ff <= 6'h3F;
        else if (bus_resp.resp) gap_ff <= 6'h00;
        else if (gap_ff != 6'h3F) gap_ff <= gap_ff + 6'h01;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_grant_onehot: assert property ($onehot0(bg))
        else $error("grant not one-hot");
    a_cmd_holds: assert property (bus_cmd.cmd && !bus_resp.resp |=> $stable(bus_cmd))
        else $error("command changed before response");
    a_word_gap: assert property ($rose(bus_cmd.cmd) |-> gap_ff > WCNT_MAX)
        else $error("bus words too close");
    a_word_only: assert property (!bus_cmd.byte_en)
        else $error("byte transfer issued");
    a_grant_busy: assert property (bg != '0 |-> cpu_hold)
        else $error("grant while not busy");
    a_dma_quiet: assert property (npg |-> bg == '0 && !bus_cmd.cmd)
        else $error("bus used during dma grant");
    a_npg_drop: assert property (!npr_pin [*6] |-> !npg)
        else $error("dma grant kept without request");
    a_vec_ends: assert property (bg != '0 && vec_valid |=> bg == '0)
        else $error("grant kept after vector");
    a_psw_first: assert property ($fell(|bg) |-> ##[1:70] bus_cmd.cmd && bus_cmd.wr)
        else $error("no status push after vector");
    a_ctx_pulse: assert property (ctx_load |=> !ctx_load)
        else $error("context load not a pulse");
endmodule // pvi_core_asserts
bind pvi_core pvi_core_asserts #(.LEVELS(LEVELS)) pvi_core_asserts_inst (.clk(clk), .rst_n(rst_n),
    .npr_pin(npr_pin), .vec_valid(vec_valid), .bus_cmd(bus_cmd), .bus_resp(bus_resp), .bg(bg),
    .npg(npg), .cpu_hold(cpu_hold), .ctx_load(ctx_load));

/* pvi_bus_partner.sv */
// partner: memory slave and vectoring device on the far side
`timescale 1ns/1ps
module pvi_bus_partner
    import pvi_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // from the sequencer, and the response latency from the testbench
    input wire pvi_pkg::pvi_cmd_t bus_cmd,
    input wire logic [3:0] bg,
    input wire logic [3:0] lat,
    // answers
    output pvi_pkg::pvi_resp_t bus_resp,
    output logic vec_valid,
    output logic [15:0] vec_in
);
    logic [15:0] mem [0:511];
    logic [3:0] wait_ff;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_ff <= 4'h0;
            bus_resp <= '0;
            vec_valid <= 1'b0;
            vec_in <= 16'h0000;
        end else begin
            bus_resp.resp <= 1'b0;
            bus_resp.rdata <= ~bus_resp.rdata;
            vec_valid <= 1'b0;
            vec_in <= ~vec_in;
            wait_ff <= wait_ff + 4'h1;
            if (bus_cmd.cmd && !bus_resp.resp && wait_ff >= lat) begin
                bus_resp.resp <= 1'b1;
                bus_resp.rdata <= mem[bus_cmd.addr[9:1]];
                if (bus_cmd.wr) mem[bus_cmd.addr[9:1]] <= bus_cmd.wdata;
                wait_ff <= 4'h0;
            end
            if (bg != 4'h0 && !vec_valid && wait_ff >= lat) begin
                vec_valid <= 1'b1;
                vec_in <= {9'h000, 1'b1, 2'b00, bg[3] | bg[2], bg[3] | bg[1], 2'b00};
                wait_ff <= 4'h0;
            end
        end
    end
endmodule // pvi_bus_partner

/* pvi_core_tb.sv */
// testbench: random and corner stimulus for the interrupt sequencer
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_count++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module pvi_core_tb;
    import pvi_pkg::*;
    logic clk, rst_n, npr_pin, pwr_fail_pin, rti_req, cpu_idle, vec_valid, npg, cpu_hold;
    logic ctx_load, halted;
    logic [3:0] br_pin, bg, lat;
    logic [15:0] vec_in, pc_in, psw_in, pc_out, psw_out, sp_out, pcx, spx;
    pvi_cmd_t bus_cmd;
    pvi_resp_t bus_resp;
    logic [31:0] seed = 32'h0000343E;
    int err_count = 0;
    int compares = 0;
    assign psw_in = psw_out;
    pvi_core pvi_core_inst (.clk(clk), .rst_n(rst_n), .br_pin(br_pin), .npr_pin(npr_pin),
        .pwr_fail_pin(pwr_fail_pin), .vec_valid(vec_valid), .vec_in(vec_in), .rti_req(rti_req),
        .pc_in(pc_in), .psw_in(psw_in), .cpu_idle(cpu_idle), .bus_cmd(bus_cmd),
        .bus_resp(bus_resp), .bg(bg), .npg(npg), .cpu_hold(cpu_hold), .pc_out(pc_out),
        .psw_out(psw_out), .sp_out(sp_out), .ctx_load(ctx_load), .halted(halted));
    pvi_bus_partner pvi_bus_partner_inst (.clk(clk), .rst_n(rst_n), .bus_cmd(bus_cmd), .bg(bg),
        .lat(lat), .bus_resp(bus_resp), .vec_valid(vec_valid), .vec_in(vec_in));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic results();
        if (err_count == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [15:0] m(input logic [15:0] a);
        return pvi_bus_partner_inst.mem[a[9:1]];
    endfunction
    task automatic wait_on(input int w);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
            if (n > 3000) begin err_count++; results(); end
        end while (!((w == 0 && ctx_load === 1'b1) || (w == 1 && bg !== 4'h0) ||
                     (w == 2 && npg === 1'b1) || (w == 3 && halted === 1'b1)));
        @(negedge clk);
    endtask
    task automatic quiet(input int n);
        repeat (n) begin
            @(negedge clk);
            `CHK(bg, 4'h0)
        end
    endtask
    task automatic take_irq(input int i);
        logic [15:0] sp0, ps0, v;
        v = 16'h0040 + 16'(i * 4);
        sp0 = sp_out;
        ps0 = psw_out;
        pcx = 16'(rnd());
        pc_in = pcx;
        br_pin = (4'h1 << i) | (4'(rnd()) & ((4'h1 << i) - 4'h1));
        wait_on(1);
        `CHK(bg, 4'h1 << i)
        wait_on(0);
        br_pin = 4'h0;
        `CHK(pc_out, m(v))
        `CHK(psw_out, m(v + 16'h2))
        `CHK(m(sp0 - 16'h2), ps0)
        `CHK(m(sp0 - 16'h4), pcx)
        `CHK(sp_out, sp0 - 16'h4)
    endtask
    task automatic rti();
        logic [15:0] sp0;
        sp0 = sp_out;
        rti_req = 1'b1;
        wait_on(0);
        rti_req = 1'b0;
        @(negedge clk);
        `CHK(pc_out, m(sp0))
        `CHK(psw_out, m(sp0 + 16'h2))
        `CHK(sp_out, sp0 + 16'h4)
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {br_pin, npr_pin, pwr_fail_pin, rti_req, pc_in} = '0;
        cpu_idle = 1'b1;
        lat = 4'h2;
        rst_n = 1'b0;
        for (int i = 0; i < 4; i++) begin
            pvi_bus_partner_inst.mem[9'h020 + 9'(2 * i)] = 16'h1000 + 16'(i * 256);
            pvi_bus_partner_inst.mem[9'h021 + 9'(2 * i)] = (i == 0) ? 16'h00C0 : 16'((i + 4) * 32);
        end
        pvi_bus_partner_inst.mem[9'h100] = 16'h0400;
        pvi_bus_partner_inst.mem[9'h101] = 16'h0000;
        pvi_bus_partner_inst.mem[9'h00C] = 16'h0777;
        pvi_bus_partner_inst.mem[9'h00D] = 16'h00E0;
        repeat (8) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        `CHK(psw_out, PSW_RST)
        `CHK(sp_out, SP_RST)
        br_pin = 4'hF;
        quiet(20);
        br_pin = 4'h0;
        rti();
        for (int i = 0; i < 4; i++) begin
            lat = 4'(rnd());
            take_irq(i);
            rti();
        end
        take_irq(1);
        @(negedge clk);
        br_pin = 4'h3;
        quiet(20);
        take_irq(2);
        rti();
        rti();
        npr_pin = 1'b1;
        br_pin = 4'h8;
        wait_on(2);
        `CHK(bg, 4'h0)
        `CHK(cpu_hold, 1'b1)
        spx = pc_out;
        repeat (30) @(negedge clk);
        {npr_pin, br_pin} = '0;
        repeat (8) @(negedge clk);
        `CHK(npg, 1'b0)
        `CHK(pc_out, spx)
        pcx = 16'(rnd());
        pc_in = pcx;
        spx = sp_out;
        pwr_fail_pin = 1'b1;
        wait_on(3);
        `CHK(m(spx - 16'h2), 16'h0000)
        `CHK(m(spx - 16'h4), pcx)
        pwr_fail_pin = 1'b0;
        wait_on(0);
        `CHK(pc_out, 16'h0777)
        `CHK(psw_out, 16'h00E0)
        `CHK(halted, 1'b0)
        results();
    end
endmodule // pvi_core_tb
